// >>> design/rdmb_cmd_path.v
// Contract
// RQ1 - command and address delayed one link clock
// RQ2 - mode load with banks 00 stores word
// RQ3 - dll reset bit clears itself after write
// RQ4 - mode rewrite never touches stored data
// RQ5 - host loads mode only when idle
// RQ6 - fields: length, order, latency, operating mode
// RQ7 - lengths 2, 4, 8, both orders
// RQ8 - host never programs reserved codes; the testbench loads length code 4 once and the block flags it on mode_reserved
// RQ9 - burst wraps inside aligned block
// RQ10 - low column bits give start offset
// RQ11 - top column bits 9, 11, optionally 12
// RQ12 - order bit: sequential clear, interleaved set
// RQ13 - sequential counts up, interleaved xors count
// RQ14 - read data due at edge n plus m
// RQ15 - host picks latency to suit frequency
// RQ16 - upper bits zero normal, bit 8 dll
// RQ17 - all strobes low is mode load
// RQ18 - length and latency codes, others reserved
// RQ19 - host adds one clock for register stage
`include "rdmb_map.vh"

module rdmb_cmd_path #(
  parameter LARGE_DENSITY = 1'b1   // 1 adds column bit 12
) (
  input  wire        mclk,
  input  wire        reset,
  input  wire        ce,
  input  wire        diff_clock_true,
  input  wire        diff_clock_complement,
  input  wire        cmd_select_n,
  input  wire        row_strobe_n,
  input  wire        col_strobe_n,
  input  wire        write_en_n,
  input  wire        bank_select_low,
  input  wire        bank_select_high,
  input  wire [12:0] addr_in,
  output reg         fwd_select_n,
  output reg         fwd_row_strobe_n,
  output reg         fwd_col_strobe_n,
  output reg         fwd_write_en_n,
  output reg  [1:0]  fwd_bank,
  output reg  [12:0] fwd_addr,
  output reg  [12:0] mode_word,
  output reg         dll_reset_pulse,
  output reg         mode_reserved,
  output reg         rd_data_due,
  output wire        col_valid,
  output wire [11:0] col_addr,
  output wire        col_is_write,
  input  wire        col_ready
);

  // ****************************************************************
  // functions
  // ****************************************************************

  // beats per burst from length code, zero when reserved
  function [3:0] rdmb_beats;
    input [2:0] code;
    begin
      case (code)
        `RDMB_BL_2: rdmb_beats = 4'h2;       // RQ18
        `RDMB_BL_4: rdmb_beats = 4'h4;       // RQ18
        `RDMB_BL_8: rdmb_beats = 4'h8;       // RQ18
        default:    rdmb_beats = 4'h0;
      endcase
    end
  endfunction

  // latency in half link clocks, zero when reserved
  function [3:0] rdmb_half_lat;
    input [2:0] code;
    begin
      case (code)
        `RDMB_LAT_2:   rdmb_half_lat = `RDMB_HALF_LAT_2;   // RQ18
        `RDMB_LAT_2P5: rdmb_half_lat = `RDMB_HALF_LAT_2P5; // RQ18
        `RDMB_LAT_3:   rdmb_half_lat = `RDMB_HALF_LAT_3;   // RQ18
        default:       rdmb_half_lat = 4'h0;
      endcase
    end
  endfunction

  // offset of beat cnt within the block
  function [2:0] rdmb_offset;
    input [2:0] start;
    input [2:0] cnt;
    input       interleave;
    input [3:0] beats;
    reg   [2:0] mask;
    begin
      mask = beats[2:0] - 3'h1;
      if (beats == 4'h8)
        mask = 3'h7;
      if (interleave)
        rdmb_offset = (start ^ cnt) & mask;          // RQ13
      else
        rdmb_offset = (start + cnt) & mask;          // RQ13
    end
  endfunction

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  reg [19:0] pin_meta_ff;    // first stage, read only by second
  reg [19:0] pin_sync_ff;    // second stage
  reg        lclk_prev_ff;   // link clock one cycle back

  // two flops per pin; reset looks like link high and deselect
  always @(posedge mclk) begin
    if (reset) begin
      pin_meta_ff  <= 20'hbc000;
      pin_sync_ff  <= 20'hbc000;
      lclk_prev_ff <= 1'b1;
    end else if (ce) begin
      pin_meta_ff  <= {diff_clock_true, diff_clock_complement,
                       cmd_select_n, row_strobe_n, col_strobe_n,
                       write_en_n, bank_select_high, bank_select_low,
                       addr_in[11:0]};
      pin_sync_ff  <= pin_meta_ff;
      lclk_prev_ff <= pin_sync_ff[19];
    end
  end

  wire        s_clk_t  = pin_sync_ff[19];
  wire        s_clk_c  = pin_sync_ff[18];
  wire [3:0]  s_cmd    = pin_sync_ff[17:14];
  wire [1:0]  s_bank   = pin_sync_ff[13:12];
  // rising edge: true goes high while complement is low
  wire        lclk_rise = s_clk_t && !lclk_prev_ff && !s_clk_c;
  // falling edge gives the half clock for latency 2.5
  wire        lclk_fall = !s_clk_t && lclk_prev_ff && s_clk_c;

  // address bit 12 has its own pair, same depth as the rest
  reg a12_meta_ff;
  reg a12_sync_ff;

  // second pair for address bit 12
  always @(posedge mclk) begin
    if (reset) begin
      a12_meta_ff <= 1'b0;
      a12_sync_ff <= 1'b0;
    end else if (ce) begin
      a12_meta_ff <= addr_in[12];
      a12_sync_ff <= a12_meta_ff;
    end
  end

  wire [12:0] s_addr = {a12_sync_ff, pin_sync_ff[11:0]};

  // ****************************************************************
  // command register stage
  // ****************************************************************
  reg [3:0]  stage_cmd_ff;   // captured command strobes
  reg [1:0]  stage_bank_ff;  // captured bank selects
  reg [12:0] stage_addr_ff;  // captured address

  // capture on one link edge, forward on the next
  always @(posedge mclk) begin
    if (reset) begin
      stage_cmd_ff     <= 4'hf;
      stage_bank_ff    <= 2'h0;
      stage_addr_ff    <= 13'h0000;
      fwd_select_n     <= 1'b1;
      fwd_row_strobe_n <= 1'b1;
      fwd_col_strobe_n <= 1'b1;
      fwd_write_en_n   <= 1'b1;
      fwd_bank         <= 2'h0;
      fwd_addr         <= 13'h0000;
    end else if (ce && lclk_rise) begin
      stage_cmd_ff     <= s_cmd;                      // RQ1
      stage_bank_ff    <= s_bank;                     // RQ1
      stage_addr_ff    <= s_addr;                     // RQ1
      fwd_select_n     <= stage_cmd_ff[3];            // RQ1
      fwd_row_strobe_n <= stage_cmd_ff[2];            // RQ1
      fwd_col_strobe_n <= stage_cmd_ff[1];            // RQ1
      fwd_write_en_n   <= stage_cmd_ff[0];            // RQ1
      fwd_bank         <= stage_bank_ff;              // RQ1
      fwd_addr         <= stage_addr_ff;              // RQ1
    end
  end

  // commands act as they leave the stage
  wire is_load  = lclk_rise && (stage_cmd_ff == `RDMB_CMD_LOAD_MODE);
  wire is_read  = lclk_rise && (stage_cmd_ff == `RDMB_CMD_READ);
  wire is_write = lclk_rise && (stage_cmd_ff == `RDMB_CMD_WRITE);

  // ****************************************************************
  // mode word
  // ****************************************************************
  wire [5:0] new_opm = stage_addr_ff[`RDMB_MW_OPM_MSB:`RDMB_MW_OPM_LSB];
  wire [2:0] new_bl  = stage_addr_ff[`RDMB_MW_BL_MSB:`RDMB_MW_BL_LSB];
  wire [2:0] new_lat = stage_addr_ff[`RDMB_MW_LAT_MSB:`RDMB_MW_LAT_LSB];

  // base word only; extended word bank select is not kept here
  always @(posedge mclk) begin
    if (reset) begin
      mode_word       <= `RDMB_MW_RESET;
      dll_reset_pulse <= 1'b0;
      mode_reserved   <= 1'b0;
    end else if (ce) begin
      dll_reset_pulse <= 1'b0;
      if (is_load && stage_bank_ff == `RDMB_BANK_BASE) begin // RQ2 RQ17
        // stored data paths are untouched by a mode load
        mode_word <= stage_addr_ff;                           // RQ2 RQ4
        dll_reset_pulse <= (new_opm == `RDMB_OPM_DLL_RESET);  // RQ16
        mode_reserved <= (rdmb_beats(new_bl) == 4'h0) ||
                         (rdmb_half_lat(new_lat) == 4'h0) ||
                         ((new_opm != `RDMB_OPM_NORMAL) &&
                          (new_opm != `RDMB_OPM_DLL_RESET));  // RQ16 RQ18
      end else if (lclk_rise) begin
        // dll reset bit does not persist past the next edge
        mode_word[`RDMB_MW_DLL_BIT] <= 1'b0;                  // RQ3
      end
    end
  end

  // decoded view of the stored word
  wire [3:0] cur_beats  = rdmb_beats(
                 mode_word[`RDMB_MW_BL_MSB:`RDMB_MW_BL_LSB]);  // RQ6 RQ7
  wire       cur_order  = mode_word[`RDMB_MW_ORDER_BIT];       // RQ6 RQ12
  wire [3:0] cur_half   = rdmb_half_lat(
                 mode_word[`RDMB_MW_LAT_MSB:`RDMB_MW_LAT_LSB]); // RQ6 RQ14

  // ****************************************************************
  // read latency timer
  // ****************************************************************
  reg [3:0] lat_cnt_ff;   // half link clocks since read
  reg       lat_run_ff;   // timer active

  // counts rising and falling link edges after a read
  always @(posedge mclk) begin
    if (reset) begin
      lat_cnt_ff  <= 4'h0;
      lat_run_ff  <= 1'b0;
      rd_data_due <= 1'b0;
    end else if (ce) begin
      rd_data_due <= 1'b0;
      if (is_read && cur_half != 4'h0) begin
        // a newer read restarts the timer unless the stored latency is reserved
        lat_cnt_ff <= 4'h0;
        lat_run_ff <= 1'b1;
      end else if (lat_run_ff && (lclk_rise || lclk_fall)) begin
        if (lat_cnt_ff + 4'h1 == cur_half) begin
          rd_data_due <= 1'b1;                              // RQ14
          lat_run_ff  <= 1'b0;
        end
        lat_cnt_ff <= lat_cnt_ff + 4'h1;
      end
    end
  end

  // ****************************************************************
  // burst column sequencer
  // ****************************************************************
  localparam [1:0] ST_IDLE = 2'b01;   // no burst
  localparam [1:0] ST_RUN  = 2'b10;   // issuing columns

  reg [1:0]  state_ff;       // one-hot state
  reg [11:0] blk_base_ff;    // column with start bits cleared
  reg [2:0]  start_ff;       // start offset in block
  reg [2:0]  beat_ff;        // beat index
  reg [3:0]  beats_ff;       // burst length latched at start
  reg        order_ff;       // burst order latched at start
  reg        wr_ff;          // burst belongs to a write
  wire       buf_in_ready;   // buffer accepts a column

  // column bits: 9..0, 11, and 12 on the larger density
  wire [11:0] new_col = {stage_addr_ff[12] & (LARGE_DENSITY != 0),
                         stage_addr_ff[11],
                         stage_addr_ff[9:0]};                  // RQ11
  wire [2:0]  new_mask = (cur_beats == 4'h8) ? 3'h7 :
                         (cur_beats[2:0] - 3'h1);              // RQ10

  // loads a burst, then emits one column per accepted word
  always @(posedge mclk) begin
    if (reset) begin
      state_ff    <= ST_IDLE;
      blk_base_ff <= 12'h000;
      start_ff    <= 3'h0;
      beat_ff     <= 3'h0;
      beats_ff    <= 4'h0;
      order_ff    <= 1'b0;
      wr_ff       <= 1'b0;
    end else if (ce) begin
      if ((is_read || is_write) && cur_beats != 4'h0) begin
        // a new read or write cuts any burst short unless the stored length is reserved
        blk_base_ff <= new_col & ~{9'h000, new_mask};          // RQ9 RQ10
        start_ff    <= new_col[2:0] & new_mask;                // RQ10
        beat_ff     <= 3'h0;
        beats_ff    <= cur_beats;                              // RQ7
        order_ff    <= cur_order;                              // RQ12
        wr_ff       <= is_write;
        state_ff    <= ST_RUN;
      end else begin
        case (state_ff)
          ST_IDLE: begin
            state_ff <= ST_IDLE;
          end
          ST_RUN: begin
            if (buf_in_ready) begin
              beat_ff <= beat_ff + 3'h1;
              if ({1'b0, beat_ff} == beats_ff - 4'h1)
                state_ff <= ST_IDLE;
            end
          end
          default: begin
            state_ff <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // column of the current beat, wrapped within its block
  wire [11:0] cur_col = blk_base_ff |
      {9'h000, rdmb_offset(start_ff, beat_ff, order_ff, beats_ff)}; // RQ9 RQ13

  // ****************************************************************
  // output buffer
  // ****************************************************************
  rdmb_skid_buf #(
    .W (13)
  ) u_buf (
    .mclk      (mclk),
    .reset     (reset),
    .ce        (ce),
    .in_valid  (state_ff == ST_RUN),
    .in_data   ({wr_ff, cur_col}),
    .in_ready  (buf_in_ready),
    .out_valid (col_valid),
    .out_data  ({col_is_write, col_addr}),
    .out_ready (col_ready)
  );

endmodule // rdmb_cmd_path

// >>> design/rdmb_map.vh
`ifndef RDMB_MAP_VH
`define RDMB_MAP_VH

// ****************************************************************
// mode word field positions
// ****************************************************************
`define RDMB_MW_WIDTH        13
`define RDMB_MW_BL_LSB       0
`define RDMB_MW_BL_MSB       2
`define RDMB_MW_ORDER_BIT    3
`define RDMB_MW_LAT_LSB      4
`define RDMB_MW_LAT_MSB      6
`define RDMB_MW_OPM_LSB      7
`define RDMB_MW_OPM_MSB      12
`define RDMB_MW_DLL_BIT      8
`define RDMB_MW_RESET        13'h0000

// ****************************************************************
// field encodings
// ****************************************************************
`define RDMB_BL_2            3'h1
`define RDMB_BL_4            3'h2
`define RDMB_BL_8            3'h3
`define RDMB_LAT_2           3'h2
`define RDMB_LAT_3           3'h3
`define RDMB_LAT_2P5         3'h6
`define RDMB_OPM_NORMAL      6'h00
`define RDMB_OPM_DLL_RESET   6'h02

// ****************************************************************
// read latency in half link clocks
// ****************************************************************
`define RDMB_HALF_LAT_2      4'h4
`define RDMB_HALF_LAT_2P5    4'h5
`define RDMB_HALF_LAT_3      4'h6

// ****************************************************************
// command codes {select_n, row_n, col_n, we_n} and bank selects
// ****************************************************************
`define RDMB_CMD_LOAD_MODE   4'h0
`define RDMB_CMD_READ        4'h5
`define RDMB_CMD_WRITE       4'h4
`define RDMB_BANK_BASE       2'h0
`define RDMB_BANK_EXT        2'h1

`endif

// >>> design/rdmb_skid_buf.v
// ****************************************************************
// two-entry buffer, outputs straight from flops
// ****************************************************************
module rdmb_skid_buf #(
  parameter W = 14
) (
  input  wire         mclk,
  input  wire         reset,
  input  wire         ce,
  input  wire         in_valid,
  input  wire [W-1:0] in_data,
  output reg          in_ready,
  output reg          out_valid,
  output reg  [W-1:0] out_data,
  input  wire         out_ready
);

  reg         spare_valid;         // second entry occupied
  reg [W-1:0] spare_data;          // second entry word
  reg         nxt_out_valid;
  reg [W-1:0] nxt_out_data;
  reg         nxt_spare_valid;
  reg [W-1:0] nxt_spare_data;

  // next state: head refills from spare first, keeps order
  always @* begin
    nxt_out_valid   = out_valid;
    nxt_out_data    = out_data;
    nxt_spare_valid = spare_valid;
    nxt_spare_data  = spare_data;
    if (!out_valid || out_ready) begin
      // head empties this cycle
      if (spare_valid) begin
        nxt_out_data    = spare_data;
        nxt_out_valid   = 1'b1;
        nxt_spare_valid = in_valid && in_ready;
        nxt_spare_data  = in_data;
      end else begin
        nxt_out_valid = in_valid && in_ready;
        nxt_out_data  = in_data;
      end
    end else if (in_valid && in_ready) begin
      // head stalled, park word in spare
      nxt_spare_valid = 1'b1;
      nxt_spare_data  = in_data;
    end
  end

  // registers; ready drops only once both entries hold words
  always @(posedge mclk) begin
    if (reset) begin
      out_valid   <= 1'b0;
      out_data    <= {W{1'b0}};
      spare_valid <= 1'b0;
      spare_data  <= {W{1'b0}};
      in_ready    <= 1'b1;
    end else if (ce) begin
      out_valid   <= nxt_out_valid;
      out_data    <= nxt_out_data;
      spare_valid <= nxt_spare_valid;
      spare_data  <= nxt_spare_data;
      in_ready    <= !nxt_spare_valid;
    end
  end

endmodule // rdmb_skid_buf

// >>> test/rdmb_cmd_path_properties.sv
// ****************************************************************
// rule checker for the command path
// ****************************************************************
module rdmb_cmd_props (
  input wire        mclk,
  input wire        reset,
  input wire        ce,
  input wire        diff_clock_true,
  input wire        fwd_select_n,
  input wire        fwd_row_strobe_n,
  input wire        fwd_col_strobe_n,
  input wire        fwd_write_en_n,
  input wire [1:0]  fwd_bank,
  input wire [12:0] fwd_addr,
  input wire [12:0] mode_word,
  input wire        dll_reset_pulse,
  input wire        mode_reserved,
  input wire        rd_data_due,
  input wire        col_valid,
  input wire [11:0] col_addr,
  input wire        col_is_write,
  input wire        col_ready
);
  timeunit 1ns;
  timeprecision 100ps;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  // link clock history, same depth as the block's synchroniser
  logic [2:0] lk_ff;
  // link rise in the cycle the block sees it
  wire        lk_rise = lk_ff[1] & ~lk_ff[2];
  // forwarded command code
  wire [3:0]  fcmd = {fwd_select_n, fwd_row_strobe_n,
                      fwd_col_strobe_n, fwd_write_en_n};
  wire [2:0]  bl = fwd_addr[2:0];
  wire [2:0]  lat = fwd_addr[6:4];
  // forwarded word carries a reserved code
  wire        rsv = bl == 3'h0 || bl > 3'h3 ||
                    !(lat == 3'h2 || lat == 3'h3 || lat == 3'h6) ||
                    !(fwd_addr[12:7] == 6'h00 || fwd_addr[12:7] == 6'h02);
  // stored length is usable, stored latency field
  wire        bl_ok = mode_word[2:0] != 3'h0 && mode_word[2:0] < 3'h4;
  wire [2:0]  mlat = mode_word[6:4];
  // a read leaves the register stage
  wire        rd_fwd = fcmd == 4'h5;

  // sample the link clock, frozen by ce like the block
  always @(posedge mclk) begin
    if (ce)
      lk_ff <= {lk_ff[1:0], diff_clock_true};
  end

  fwd_on_rise_a:
    assert property ($changed(fwd_addr) |-> $past(lk_rise) ||
      $past(lk_rise, 2)) else $error("forwarded word moved off a rise");
  mode_load_a:
    assert property ($changed(mode_word) |-> (fcmd == 4'h0 &&
      fwd_bank == 2'h0 && mode_word == fwd_addr) ||
      mode_word == ($past(mode_word) & 13'h1eff))
      else $error("mode word changed without a base load");
  dll_pulse_a:
    assert property (dll_reset_pulse |-> (fwd_addr[12:7] == 6'h02 &&
      fcmd == 4'h0 && fwd_bank == 2'h0) ##1 !dll_reset_pulse)
      else $error("dll pulse without a dll load");
  dll_clear_a:
    assert property ($rose(mode_word[8]) |-> ##[1:12] !mode_word[8])
      else $error("dll bit did not clear");
  rsv_flag_a:
    assert property ($rose(mode_reserved) |-> rsv)
      else $error("reserved flag on a legal word");
  due_once_a:
    assert property (rd_data_due |=> !rd_data_due)
      else $error("read due longer than one cycle");
  lat_two_a:
    assert property ($fell(fwd_col_strobe_n) && rd_fwd && mlat == 3'h2
      |-> ##16 rd_data_due) else $error("latency 2 off");
  lat_half_a:
    assert property ($fell(fwd_col_strobe_n) && rd_fwd && mlat == 3'h6
      |-> ##20 rd_data_due) else $error("latency 2.5 off");
  lat_three_a:
    assert property ($fell(fwd_col_strobe_n) && rd_fwd && mlat == 3'h3
      |-> ##24 rd_data_due) else $error("latency 3 off");
  col_hold_a:
    assert property (col_valid && !col_ready |=> col_valid &&
      $stable(col_addr) && $stable(col_is_write))
      else $error("column word lost on stall");
  col_start_a:
    assert property ($fell(fwd_col_strobe_n) && !fwd_select_n &&
      fwd_row_strobe_n && bl_ok |-> ##2 col_valid)
      else $error("burst did not start");
endmodule // rdmb_cmd_props

bind rdmb_cmd_path rdmb_cmd_props u_props (
  .mclk, .reset, .ce, .diff_clock_true, .fwd_select_n, .fwd_row_strobe_n,
  .fwd_col_strobe_n, .fwd_write_en_n, .fwd_bank, .fwd_addr, .mode_word,
  .dll_reset_pulse, .mode_reserved, .rd_data_due, .col_valid, .col_addr,
  .col_is_write, .col_ready
);

// >>> test/rdmb_host_model.sv
// ****************************************************************
// host controller model: link clock and command pins
// ****************************************************************
module rdmb_host_model (
  output logic        diff_clock_true,
  output logic        diff_clock_complement,
  output logic        cmd_select_n,
  output logic        row_strobe_n,
  output logic        col_strobe_n,
  output logic        write_en_n,
  output logic        bank_select_low,
  output logic        bank_select_high,
  output logic [12:0] addr_in
);
  timeunit 1ns;
  timeprecision 100ps;

  // free-running 80 ns link clock, phase offset from mclk
  // latency is counted in link edges, so each test picks its own
  initial begin
    diff_clock_true = 1'b0;
    diff_clock_complement = 1'b1;
    {cmd_select_n, row_strobe_n, col_strobe_n, write_en_n} = 4'hf;
    {bank_select_high, bank_select_low} = 2'h0;
    addr_in = 13'h0000;
    #3;
    forever begin
      #40;
      diff_clock_true = ~diff_clock_true;
      diff_clock_complement = ~diff_clock_true;
    end
  end

  // one command per link clock, pins change on the falling edge;
  // results are expected one link clock late for the register stage
  task automatic issue(input logic [3:0] c, input logic [1:0] b,
                       input logic [12:0] a);
    @(negedge diff_clock_true);
    {cmd_select_n, row_strobe_n, col_strobe_n, write_en_n} = c;
    {bank_select_high, bank_select_low} = b;
    addr_in = a;
    @(negedge diff_clock_true);
    // deselect; released lines show the inverse, not the old value
    {cmd_select_n, row_strobe_n, col_strobe_n, write_en_n} = 4'hf;
    {bank_select_high, bank_select_low} = ~b;
    addr_in = ~a;
  endtask

  // idle link clocks, the recovery time after a mode load
  task automatic idle(input int n);
    repeat (n) @(negedge diff_clock_true);
  endtask
endmodule // rdmb_host_model

// >>> test/tb_top.sv
// ****************************************************************
// compare helper
// ****************************************************************
`define CHK(got, exp) begin \
  comparisons++; \
  if ((got) !== (exp)) begin \
    error_cnt++; \
    $display("mismatch at %0t: got %h expected %h", $time, got, exp); \
  end \
end

module tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  logic        mclk, reset, ce, col_ready, hold;
  logic        diff_clock_true, diff_clock_complement;
  logic        cmd_select_n, row_strobe_n, col_strobe_n, write_en_n;
  logic        bank_select_low, bank_select_high;
  logic [12:0] addr_in, fwd_addr, mode_word;
  logic        fwd_select_n, fwd_row_strobe_n, fwd_col_strobe_n;
  logic        fwd_write_en_n, dll_reset_pulse, mode_reserved;
  logic        rd_data_due, col_valid, col_is_write;
  logic [1:0]  fwd_bank, stall;
  logic [11:0] col_addr;
  int          error_cnt, comparisons, dll_seen;
  logic [12:0] beats [$];  // accepted {write, column} beats

  rdmb_cmd_path u_dut (
    .mclk, .reset, .ce, .diff_clock_true, .diff_clock_complement,
    .cmd_select_n, .row_strobe_n, .col_strobe_n, .write_en_n,
    .bank_select_low, .bank_select_high, .addr_in, .fwd_select_n,
    .fwd_row_strobe_n, .fwd_col_strobe_n, .fwd_write_en_n, .fwd_bank,
    .fwd_addr, .mode_word, .dll_reset_pulse, .mode_reserved,
    .rd_data_due, .col_valid, .col_addr, .col_is_write, .col_ready
  );

  rdmb_host_model u_host (
    .diff_clock_true, .diff_clock_complement, .cmd_select_n,
    .row_strobe_n, .col_strobe_n, .write_en_n, .bank_select_low,
    .bank_select_high, .addr_in
  );

  // 100 MHz system clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // consumer: stalls one cycle in four, or while held
  always @(negedge mclk) begin
    stall <= stall + 2'h1;
    col_ready <= !hold && stall != 2'h3;
  end

  // collect accepted beats, count dll pulses
  always @(posedge mclk) begin
    if (col_valid && col_ready)
      beats.push_back({col_is_write, col_addr});
    if (dll_reset_pulse)
      dll_seen++;
  end

  // ****************************************************************
  // tasks
  // ****************************************************************
  // mode load followed by recovery time
  task automatic load(input logic [12:0] w, input logic [1:0] b);
    u_host.issue(4'h0, b, w);
    u_host.idle(2);
  endtask

  // mclk cycles from forwarded read to read-due pulse
  task automatic lat_check(input logic [2:0] code, input int exp);
    int n;
    load({6'h00, code, 4'h1}, 2'h0);
    u_host.issue(4'h5, 2'h0, 13'h0404);
    n = 0;
    while (fwd_col_strobe_n !== 1'b0 && n < 40) begin
      @(negedge mclk);
      n++;
    end
    `CHK(fwd_addr, 13'h0404)
    n = 0;
    while (rd_data_due !== 1'b1 && n < 40) begin
      @(negedge mclk);
      n++;
    end
    `CHK(n, exp)
    u_host.idle(2);
  endtask

  // one burst; start 0 is a write, others reads
  task automatic burst(input int len, input logic ord, input int s);
    logic [2:0]  bl;
    logic [11:0] e;
    bl = (len == 2) ? 3'h1 : (len == 4) ? 3'h2 : 3'h3;
    load({6'h00, 3'h2, ord, bl}, 2'h0);
    beats.delete();
    hold = (s == len - 1);
    u_host.issue(s == 0 ? 4'h4 : 4'h5, 2'h0, 13'h1aa8 | 13'(s));
    u_host.idle(3);
    hold = 1'b0;
    u_host.idle(2);
    `CHK(beats.size(), len)
    for (int i = 0; i < len; i++) begin
      e = 12'hea8 | 12'(ord ? (s ^ i) : ((s + i) % len));
      `CHK(beats[i], {s == 0, e})
    end
  endtask

  // counts, verdict and end of run
  task automatic print_verdict();
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    reset = 1'b1;
    ce = 1'b1;
    hold = 1'b0;
    stall = 2'h0;
    col_ready = 1'b1;
    error_cnt = 0;
    comparisons = 0;
    dll_seen = 0;
    repeat (12) @(negedge mclk);
    reset = 1'b0;
    repeat (4) @(negedge mclk);
    `CHK(fwd_select_n, 1'b1)
    `CHK(mode_word, 13'h0000)
    `CHK(col_valid, 1'b0)
    // clock enable low: a load on the pins is never taken
    @(negedge mclk) ce = 1'b0;
    u_host.issue(4'h0, 2'h0, 13'h0031);
    @(negedge mclk) ce = 1'b1;
    u_host.idle(2);
    `CHK(mode_word, 13'h0000)
    // extended word ignored, dll load pulses and self-clears
    load(13'h0033, 2'h1);
    `CHK(mode_word, 13'h0000)
    load(13'h0132, 2'h0);
    `CHK(dll_seen, 1)
    u_host.idle(1);
    `CHK(mode_word, 13'h0032)
    `CHK(mode_reserved, 1'b0)
    // reserved length is flagged and starts no burst
    load(13'h0024, 2'h0);
    `CHK(mode_reserved, 1'b1)
    beats.delete();
    u_host.issue(4'h5, 2'h0, 13'h0000);
    u_host.idle(4);
    `CHK(beats.size(), 0)
    lat_check(3'h2, 16);
    lat_check(3'h6, 20);
    lat_check(3'h3, 24);
    for (int o = 0; o < 2; o++)
      for (int l = 2; l <= 8; l = l * 2)
        for (int s = 0; s < l; s++)
          burst(l, o[0], s);
    print_verdict();
  end

  // watchdog against a hung run
  initial begin
    #60000;
    error_cnt++;
    $display("mismatch at %0t: run did not finish", $time);
    print_verdict();
  end
endmodule // tb_top
